// ### rtf_pkg.sv
/*
 * Shared constants and types of the target report framer: serial line
 * settings, frame period, frame layout and state encodings.
 * Assumes a single system clock of CLK_HZ feeding every module.
 */
package rtf_pkg;

	// ------------------------------------------------------------
	// Clock and serial line
	// ------------------------------------------------------------
	localparam int unsigned CLK_HZ        = 50_000_000;
	localparam int unsigned BAUD_RATE     = 256_000;
	localparam int unsigned BIT_CYCLES    = CLK_HZ / BAUD_RATE;
	localparam int unsigned DATA_BITS     = 8;
	localparam int unsigned BITN_W        = $clog2(DATA_BITS);
	localparam int unsigned STOP_BITS     = 1;
	localparam logic        LINE_IDLE     = 1'b1;
	localparam logic        START_LEVEL   = 1'b0;
	localparam logic        STOP_LEVEL    = 1'b1;

	// ------------------------------------------------------------
	// Frame period
	// ------------------------------------------------------------
	localparam int unsigned FRAME_RATE_HZ = 10;
	localparam int unsigned FRAME_CYCLES  = CLK_HZ / FRAME_RATE_HZ;

	// ------------------------------------------------------------
	// Frame layout
	// ------------------------------------------------------------
	localparam int unsigned HDR_LEN        = 4;
	localparam int unsigned TRL_LEN        = 2;
	localparam int unsigned NUM_TARGETS    = 3;
	localparam int unsigned FIELD_BYTES    = 2;
	localparam int unsigned FIELDS_PER_REC = 4;
	localparam int unsigned REC_LEN        = FIELDS_PER_REC * FIELD_BYTES;
	localparam int unsigned BODY_END       = HDR_LEN + NUM_TARGETS * REC_LEN;
	localparam int unsigned FRAME_LEN      = BODY_END + TRL_LEN;
	localparam int unsigned FLD_COUNT      = NUM_TARGETS * FIELDS_PER_REC;
	localparam int unsigned IDX_W          = $clog2(FRAME_LEN);
	localparam logic [0:HDR_LEN-1][7:0] HDR_BYTES =
		'{8'hAA, 8'hFF, 8'h03, 8'h00};
	localparam logic [0:TRL_LEN-1][7:0] TRL_BYTES = '{8'h55, 8'hCC};
	localparam logic [7:0]  EMPTY_BYTE     = 8'h00;

	// Field positions inside one record
	localparam int unsigned FLD_X          = 0;
	localparam int unsigned FLD_Y          = 1;
	localparam int unsigned FLD_SPD        = 2;
	localparam int unsigned FLD_GATE       = 3;

	// Sign-magnitude field coding
	localparam logic [15:0] SIGN_POS       = 16'h8000;
	localparam logic [15:0] MAG_MAX        = 16'h7FFF;

	localparam int unsigned FIFO_DEPTH     = 8;

	// ------------------------------------------------------------
	// State encodings
	// ------------------------------------------------------------
	typedef enum logic [0:0] {
		BLD_IDLE = 1'b0,
		BLD_SEND = 1'b1
	} rtf_bld_state_t;

	typedef enum logic [1:0] {
		TX_IDLE  = 2'b00,
		TX_START = 2'b01,
		TX_DATA  = 2'b10,
		TX_STOP  = 2'b11
	} rtf_tx_state_t;

endpackage : rtf_pkg

// ### rtf_byte_if.sv
/*
 * Valid/ready byte stream between the framer's own modules.
 * Assumes both ends run on the same clock.
 */
interface rtf_byte_if #(
	parameter int unsigned WIDTH = 8
);
	logic [WIDTH-1:0] data;
	logic             valid;
	logic             ready;

	modport src (output data, output valid, input ready);
	modport snk (input data, input valid, output ready);
endinterface : rtf_byte_if

// ### rtf_fifo.sv
/*
 * Synchronous FIFO with valid/ready on both sides.
 * Assumes one clock and a synchronous active-high reset; DEPTH >= 2.
 */
module rtf_fifo import rtf_pkg::*; #(
	parameter int unsigned WIDTH = 8,
	parameter int unsigned DEPTH = FIFO_DEPTH
) (
	input  wire logic mclk_i,
	input  wire logic srst_i,
	rtf_byte_if.snk   wr,
	rtf_byte_if.src   rd
);

	localparam int unsigned PTR_W = $clog2(DEPTH);
	localparam int unsigned CNT_W = $clog2(DEPTH + 1);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PTR_W-1:0] wr_ptr;
	logic [PTR_W-1:0] rd_ptr;
	logic [CNT_W-1:0] count;
	logic [PTR_W-1:0] next_wr_ptr;
	logic [PTR_W-1:0] next_rd_ptr;
	logic [CNT_W-1:0] next_count;
	logic             push;
	logic             pop;

	// ------------------------------------------------------------
	// Handshake
	// ------------------------------------------------------------
	// Full and empty come straight from the count, so a stalled reader
	// really fills the store and pushes back on the writer.
	assign wr.ready = (count != CNT_W'(DEPTH));
	assign rd.valid = (count != '0);
	assign rd.data  = mem[rd_ptr];
	assign push     = wr.valid && wr.ready;
	assign pop      = rd.valid && rd.ready;

	// Pointer arithmetic wraps at DEPTH, which need not be a power of 2
	function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
		if (p == PTR_W'(DEPTH - 1)) begin
			return '0;
		end
		return p + PTR_W'(1);
	endfunction : ptr_inc

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		next_wr_ptr = push ? ptr_inc(wr_ptr) : wr_ptr;
		next_rd_ptr = pop ? ptr_inc(rd_ptr) : rd_ptr;
		next_count  = count;
		if (push && !pop) begin
			next_count = count + CNT_W'(1);
		end else if (pop && !push) begin
			next_count = count - CNT_W'(1);
		end
	end

	// Registers
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			count  <= next_count;
		end
	end

	// Storage needs no reset; empty hides its contents
	always_ff @(posedge mclk_i) begin
		if (push) begin
			mem[wr_ptr] <= wr.data;
		end
	end

endmodule : rtf_fifo

// ### rtf_framer.sv
/*
 * Target report framer: every frame period it snapshots three target
 * records, builds the 30-byte frame into a FIFO and sends it out as
 * 8N1 serial characters on txd_o.
 * Assumes target inputs are synchronous to mclk_i and held by the
 * radar processing; they are sampled once at the start of each frame.
 * Assumes a frame fits inside one period; a late frame is held
 * pending and starts as soon as the builder is free.
 */
//
// Overview of operation
// - Line runs 256000 baud, one stop bit, no parity; host matches.
// - A complete frame is started every 100 ms, ten per second.
// - Frame is AA FF 03 00, targets one to three, then 55 CC.
// - Three fixed record slots per frame, one per possible target.
// - X and y in mm; bit 15 set positive, clear negative magnitude.
// - Speed in cm/s; bit 15 is sign, low fifteen bits magnitude.
// - Record ends with unsigned 16-bit distance gate size in mm.
// - A slot without a tracked target sends all zero bytes.
// - Sixteen-bit fields go low byte first, then high byte.
module rtf_framer import rtf_pkg::*; #(
	parameter int unsigned FRAME_CYCLES_P = FRAME_CYCLES,
	parameter int unsigned BIT_CYCLES_P   = BIT_CYCLES
) (
	input  wire logic                        mclk_i,
	input  wire logic                        srst_i,
	input  wire logic [NUM_TARGETS-1:0]      tgt_valid_i,
	input  wire logic [NUM_TARGETS-1:0][15:0] tgt_x_i,
	input  wire logic [NUM_TARGETS-1:0][15:0] tgt_y_i,
	input  wire logic [NUM_TARGETS-1:0][15:0] tgt_speed_i,
	input  wire logic [NUM_TARGETS-1:0][15:0] tgt_gate_i,
	output      logic                        txd_o,
	output      logic                        frame_start_o,
	output      logic                        frame_busy_o
);

	localparam int unsigned FRAME_W = $clog2(FRAME_CYCLES_P + 1);
	localparam int unsigned BAUD_W  = $clog2(BIT_CYCLES_P + 1);

	// ------------------------------------------------------------
	// Field coding
	// ------------------------------------------------------------
	// Two's complement in, sign-magnitude out; -32768 has no 15-bit
	// magnitude, so it saturates rather than flipping sign.
	// Zero counts as positive and goes out with only bit 15 set.
	function automatic logic [15:0] enc_signed(input logic [15:0] v);
		logic [15:0] mag;
		mag = '0;
		if (!v[15]) begin
			return SIGN_POS | v;
		end
		mag = 16'(-$signed(v));
		if (mag[15]) begin
			mag = MAG_MAX;
		end
		return mag & MAG_MAX;
	endfunction : enc_signed

	// Frame map, byte positions:
	//   0 to 3    header
	//   4 to 11   target one: x, y, speed, gate, low byte first
	//   12 to 19  target two
	//   20 to 27  target three
	//   28 to 29  trailer
	// Positions are decoded on the fly, so no frame buffer is kept.
	// Byte of the frame at position idx, from the frame's snapshot
	function automatic logic [7:0] frame_byte(
		input logic [IDX_W-1:0]                idx,
		input logic [NUM_TARGETS-1:0]          vld,
		input logic [FLD_COUNT-1:0][15:0]      fld
	);
		int unsigned off;
		int unsigned slot;
		int unsigned fno;
		logic [15:0] word;
		off  = 0;
		slot = 0;
		fno  = 0;
		word = '0;
		if (int'(idx) < HDR_LEN) begin
			return HDR_BYTES[idx];
		end
		if (int'(idx) >= BODY_END) begin
			return TRL_BYTES[int'(idx) - BODY_END];
		end
		// Record bytes: slot, field within slot, byte within field
		off  = int'(idx) - HDR_LEN;
		slot = off / REC_LEN;
		fno  = (off % REC_LEN) / FIELD_BYTES;
		word = fld[slot * FIELDS_PER_REC + fno];
		if (!vld[slot]) begin
			return EMPTY_BYTE;
		end
		if (off % FIELD_BYTES == 0) begin
			return word[7:0];
		end
		return word[15:8];
	endfunction : frame_byte

	// ------------------------------------------------------------
	// Internal streams
	// ------------------------------------------------------------
	// The builder makes bytes far faster than the line drains them;
	// the FIFO lets it run ahead and keeps the transmitter fed.
	rtf_byte_if #(.WIDTH(DATA_BITS)) bld_q ();
	rtf_byte_if #(.WIDTH(DATA_BITS)) tx_q ();

	rtf_fifo #(
		.WIDTH (DATA_BITS),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.mclk_i (mclk_i),
		.srst_i (srst_i),
		.wr     (bld_q.snk),
		.rd     (tx_q.src)
	);

	// ------------------------------------------------------------
	// Frame period and builder
	// ------------------------------------------------------------
	rtf_bld_state_t                bld_state;
	rtf_bld_state_t                next_bld_state;
	logic [FRAME_W-1:0]            period_cnt;
	logic [FRAME_W-1:0]            next_period_cnt;
	logic                          pending;
	logic                          next_pending;
	logic [IDX_W-1:0]              byte_idx;
	logic [IDX_W-1:0]              next_byte_idx;
	logic [NUM_TARGETS-1:0]        snap_vld;
	logic [NUM_TARGETS-1:0]        next_snap_vld;
	logic [FLD_COUNT-1:0][15:0]    snap_fld;
	logic [FLD_COUNT-1:0][15:0]    next_snap_fld;
	logic                          next_frame_start;
	logic                          period_tick;
	logic                          start;

	// Free-running period; a late frame is held pending, never dropped
	assign period_tick = (period_cnt == FRAME_W'(FRAME_CYCLES_P - 1));
	assign start       = (bld_state == BLD_IDLE) && (period_tick || pending);

	assign bld_q.valid = (bld_state == BLD_SEND);
	assign bld_q.data  = frame_byte(byte_idx, snap_vld, snap_fld);

	// Period counter, pending tick and builder; the snapshot is only
	// taken on the start cycle, so inputs may move at any other time.
	always_comb begin
		next_period_cnt  = period_tick ? '0
		                               : period_cnt + FRAME_W'(1);
		// A tick landing while busy is kept; consume wins over set
		next_pending     = (pending || period_tick) && !start;
		next_bld_state   = bld_state;
		next_byte_idx    = byte_idx;
		next_snap_vld    = snap_vld;
		next_snap_fld    = snap_fld;
		next_frame_start = 1'b0;
		unique case (bld_state)
			BLD_IDLE: begin
				if (start) begin
					// Snapshot keeps one frame self-consistent
					next_bld_state   = BLD_SEND;
					next_byte_idx    = '0;
					next_frame_start = 1'b1;
					next_snap_vld    = tgt_valid_i;
					for (int t = 0; t < NUM_TARGETS; t++) begin
						next_snap_fld[t * FIELDS_PER_REC + FLD_X] =
							enc_signed(tgt_x_i[t]);
						next_snap_fld[t * FIELDS_PER_REC + FLD_Y] =
							enc_signed(tgt_y_i[t]);
						next_snap_fld[t * FIELDS_PER_REC + FLD_SPD] =
							enc_signed(tgt_speed_i[t]);
						next_snap_fld[t * FIELDS_PER_REC + FLD_GATE] =
							tgt_gate_i[t];
					end
				end
			end
			BLD_SEND: begin
				// FIFO back-pressure simply stalls the byte index
				if (bld_q.ready) begin
					if (byte_idx == IDX_W'(FRAME_LEN - 1)) begin
						next_bld_state = BLD_IDLE;
					end else begin
						next_byte_idx = byte_idx + IDX_W'(1);
					end
				end
			end
		endcase
	end

	// Builder registers; reset restarts the period from zero
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			bld_state     <= BLD_IDLE;
			period_cnt    <= '0;
			pending       <= 1'b0;
			byte_idx      <= '0;
			snap_vld      <= '0;
			snap_fld      <= '0;
			frame_start_o <= 1'b0;
		end else begin
			bld_state     <= next_bld_state;
			period_cnt    <= next_period_cnt;
			pending       <= next_pending;
			byte_idx      <= next_byte_idx;
			snap_vld      <= next_snap_vld;
			snap_fld      <= next_snap_fld;
			frame_start_o <= next_frame_start;
		end
	end

	// ------------------------------------------------------------
	// Status outputs
	// ------------------------------------------------------------
	// Busy covers the build only; the last bytes still drain from the
	// FIFO through the transmitter after it drops.
	assign frame_busy_o = (bld_state == BLD_SEND);

	// ------------------------------------------------------------
	// Serial transmitter
	// ------------------------------------------------------------
	rtf_tx_state_t           tx_state;
	rtf_tx_state_t           next_tx_state;
	logic [BAUD_W-1:0]       baud_cnt;
	logic [BAUD_W-1:0]       next_baud_cnt;
	logic [BITN_W-1:0]       bit_num;
	logic [BITN_W-1:0]       next_bit_num;
	logic [DATA_BITS-1:0]    shift;
	logic [DATA_BITS-1:0]    next_shift;
	logic                    next_txd;
	logic                    bit_done;

	// Integer bit time: 195 cycles gives 256410 baud, 0.16 % fast
	assign bit_done   = (baud_cnt == BAUD_W'(BIT_CYCLES_P - 1));
	assign tx_q.ready = (tx_state == TX_IDLE);

	// Start, eight data bits and stop each last one bit time; TX_IDLE
	// adds one cycle between characters, which costs a little line
	// rate but keeps the FIFO handshake simple.
	always_comb begin
		next_tx_state = tx_state;
		next_baud_cnt = '0;
		next_bit_num  = bit_num;
		next_shift    = shift;
		next_txd      = txd_o;
		if (tx_state != TX_IDLE && !bit_done) begin
			next_baud_cnt = baud_cnt + BAUD_W'(1);
		end
		unique case (tx_state)
			TX_IDLE: begin
				next_txd = LINE_IDLE;
				if (tx_q.valid) begin
					next_shift    = tx_q.data;
					next_txd      = START_LEVEL;
					next_tx_state = TX_START;
				end
			end
			TX_START: begin
				if (bit_done) begin
					next_txd      = shift[0];
					next_bit_num  = '0;
					next_tx_state = TX_DATA;
				end
			end
			TX_DATA: begin
				if (bit_done) begin
					if (bit_num == BITN_W'(DATA_BITS - 1)) begin
						// No parity bit: straight to the stop bit
						next_txd      = STOP_LEVEL;
						next_bit_num  = '0;
						next_tx_state = TX_STOP;
					end else begin
						next_shift   = shift >> 1;
						next_txd     = shift[1];
						next_bit_num = bit_num + BITN_W'(1);
					end
				end
			end
			TX_STOP: begin
				if (bit_done) begin
					if (bit_num == BITN_W'(STOP_BITS - 1)) begin
						next_tx_state = TX_IDLE;
					end else begin
						next_bit_num = bit_num + BITN_W'(1);
					end
				end
			end
		endcase
	end

	// Transmitter registers; the line is held idle high in reset
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			tx_state <= TX_IDLE;
			baud_cnt <= '0;
			bit_num  <= '0;
			shift    <= '0;
			txd_o    <= LINE_IDLE;
		end else begin
			tx_state <= next_tx_state;
			baud_cnt <= next_baud_cnt;
			bit_num  <= next_bit_num;
			shift    <= next_shift;
			txd_o    <= next_txd;
		end
	end

endmodule : rtf_framer

// ### rtf_framer_monitor.sv
/*
 * Port checker for the target report framer.
 * Assumes it is bound to rtf_framer: one clock, sync active-high reset.
 */
module rtf_framer_monitor #(
	parameter int unsigned FRAME_CYCLES_P = 5000000,
	parameter int unsigned BIT_CYCLES_P   = 195
) (
	input wire logic mclk_i,
	input wire logic srst_i,
	input wire logic txd_o,
	input wire logic frame_start_o,
	input wire logic frame_busy_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------
	// Helper counters
	// ----------------------------------------
	// Worst case build time: thirty characters, two spare idle cycles each
	localparam int unsigned BUSY_MAX = 30 * (10 * BIT_CYCLES_P + 2);
	logic [31:0] since_start;
	logic [31:0] low_run;
	logic        seen_start;

	// Period is only judged once a first frame has been seen
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			since_start <= 32'h0;
			low_run     <= 32'h0;
			seen_start  <= 1'b0;
		end else begin
			since_start <= frame_start_o ? 32'h0 : since_start + 32'h1;
			low_run     <= txd_o ? 32'h0 : low_run + 32'h1;
			seen_start  <= seen_start | frame_start_o;
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking @(posedge mclk_i); endclocking
	default disable iff (srst_i);

	reset_idle_a: assert property (
		$fell(srst_i) |-> txd_o && !frame_start_o && !frame_busy_o)
		else $error("outputs not idle after reset");
	start_pulse_a: assert property (
		frame_start_o |=> !frame_start_o)
		else $error("frame start longer than one cycle");
	start_txd_a: assert property (
		frame_start_o |-> txd_o ##2 !txd_o)
		else $error("first start bit not two cycles after frame start");
	period_due_a: assert property (
		seen_start && since_start == FRAME_CYCLES_P - 1 |-> frame_start_o)
		else $error("frame not started when period ran out");
	period_early_a: assert property (
		frame_start_o && seen_start |-> since_start == FRAME_CYCLES_P - 1)
		else $error("frame started off period");
	busy_rise_a: assert property (
		$rose(frame_busy_o) |-> frame_start_o)
		else $error("build began without frame start");
	busy_len_a: assert property (
		frame_busy_o && !frame_start_o |-> since_start < BUSY_MAX)
		else $error("frame build too long");
	low_unit_a: assert property (
		$rose(txd_o) |-> low_run % BIT_CYCLES_P == 0)
		else $error("low run not whole bit times");
	low_max_a: assert property (
		low_run <= 9 * BIT_CYCLES_P)
		else $error("line low longer than start plus eight bits");
endmodule : rtf_framer_monitor

// ### rtf_host_rx.sv
/*
 * Host receiver model: samples the serial line mid-bit, 8N1, LSB first.
 * Assumes a bit time of BIT_CYCLES_P clocks and a line idling high.
 */
module rtf_host_rx #(
	parameter int unsigned BIT_CYCLES_P = 4
) (
	input  wire logic       mclk_i,
	input  wire logic       rxd_i,
	output      logic [7:0] byte_o,
	output      logic       stb_o,
	output      logic       err_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------
	// Character receiver
	// ----------------------------------------
	initial begin
		byte_o = 8'h00;
		stb_o  = 1'b0;
		err_o  = 1'b0;
	end

	// Mid-bit sampling tolerates a slightly fast or slow sender
	always begin
		@(negedge rxd_i);
		repeat (BIT_CYCLES_P / 2) @(posedge mclk_i);
		if (rxd_i === 1'b0) begin
			for (int i = 0; i < 8; i++) begin
				repeat (BIT_CYCLES_P) @(posedge mclk_i);
				byte_o[i] <= rxd_i;
			end
			repeat (BIT_CYCLES_P) @(posedge mclk_i);
			err_o <= (rxd_i !== 1'b1);
			stb_o <= 1'b1;
			@(posedge mclk_i);
			stb_o <= 1'b0;
			err_o <= 1'b0;
		end
	end
endmodule : rtf_host_rx

// ### tb_rtf_framer.sv
/*
 * Testbench for the target report framer, with a host receiver model.
 * Assumes short sim counts: 2000 cycle period, 4 cycle bit time.
 */
module tb import rtf_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------
	// Signals and instances
	// ----------------------------------------
	localparam int unsigned FR    = 2000;
	localparam int unsigned BT    = 4;
	localparam int unsigned LIMIT = 40000;
	logic                   mclk_i;
	logic                   srst_i;
	logic [2:0]             vld;
	logic [2:0][15:0]       tx;
	logic [2:0][15:0]       ty;
	logic [2:0][15:0]       ts;
	logic [2:0][15:0]       tg;
	logic                   txd;
	logic                   fstart;
	logic                   fbusy;
	logic [7:0]             rx_byte;
	logic                   rx_stb;
	logic                   rx_err;
	logic [7:0]             rxq[$];
	int                     n_errors;
	int                     samples_checked;
	int                     cyc;
	int                     last_start;

	rtf_framer #(.FRAME_CYCLES_P(FR), .BIT_CYCLES_P(BT)) DUT (
		.mclk_i       (mclk_i),
		.srst_i       (srst_i),
		.tgt_valid_i  (vld),
		.tgt_x_i      (tx),
		.tgt_y_i      (ty),
		.tgt_speed_i  (ts),
		.tgt_gate_i   (tg),
		.txd_o        (txd),
		.frame_start_o(fstart),
		.frame_busy_o (fbusy)
	);
	rtf_host_rx #(.BIT_CYCLES_P(BT)) u_host (
		.mclk_i(mclk_i),
		.rxd_i (txd),
		.byte_o(rx_byte),
		.stb_o (rx_stb),
		.err_o (rx_err)
	);

	// Clock
	always #10 mclk_i = ~mclk_i;

	// Byte collection, stop bit errors and the hang limit
	always @(posedge mclk_i) begin
		cyc++;
		if (rx_stb === 1'b1) rxq.push_back(rx_byte);
		if (rx_err === 1'b1) begin
			n_errors++;
			$display("CHECK FAILED at %0t: stop bit low", $time);
		end
		if (cyc == LIMIT) begin
			n_errors++;
			$display("CHECK FAILED at %0t: timeout", $time);
			give_verdict();
		end
	end

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic chk(input logic [31:0] got, exp, input string what);
		samples_checked++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED at %0t: %s got %h exp %h",
				$time, what, got, exp);
		end
	endtask : chk

	// Host-side view of a signed value as it must appear on the line
	function automatic logic [15:0] enc(input logic [15:0] v);
		if (!v[15]) return 16'h8000 | v;
		if (v == 16'h8000) return 16'h7FFF;
		return ~v + 16'h0001;
	endfunction : enc

	// Waits for a frame pulse and gives the cycles since the previous
	// pulse or reset release; old bytes are dropped at that point
	task automatic wait_start(output int n);
		int k;
		k = 0;
		do begin
			@(posedge mclk_i);
			#1;
			k++;
		end while (fstart !== 1'b1 && k < 3 * FR);
		n          = cyc - last_start;
		last_start = cyc;
		rxq.delete();
	endtask : wait_start

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic reset_and_time();
		int n;
		srst_i = 1'b1;
		repeat (5) begin
			@(posedge mclk_i);
			#1;
		end
		srst_i     = 1'b0;
		last_start = cyc;
		chk({txd, fstart, fbusy}, 32'h4, "idle after reset");
		wait_start(n);
		chk(n, FR, "first frame delay");
	endtask : reset_and_time

	// One whole frame with the given slot mask, judged byte by byte
	task automatic one_frame(input logic [2:0] v);
		int         n;
		logic [7:0]  e[$];
		logic [15:0] f[4];
		vld = v;
		wait_start(n);
		chk(n, FR, "frame period");
		e = '{8'hAA, 8'hFF, 8'h03, 8'h00};
		for (int t = 0; t < 3; t++) begin
			f = '{enc(tx[t]), enc(ty[t]), enc(ts[t]), tg[t]};
			for (int k = 0; k < 4; k++) begin
				if (!v[t]) f[k] = 16'h0000;
				e.push_back(f[k][7:0]);
				e.push_back(f[k][15:8]);
			end
		end
		e.push_back(8'h55);
		e.push_back(8'hCC);
		for (int i = 0; i < FR && rxq.size() < 30; i++) @(posedge mclk_i);
		#1;
		chk(rxq.size(), 30, "frame length");
		for (int i = 0; i < 30 && i < rxq.size(); i++) begin
			chk(rxq[i], e[i], "frame byte");
		end
	endtask : one_frame

	task automatic t_frames();
		logic [2:0] masks[4] = '{3'b111, 3'b101, 3'b010, 3'b000};
		foreach (masks[i]) one_frame(masks[i]);
	endtask : t_frames

	// Reset in the middle of a frame, then a clean frame must follow
	task automatic t_mid_reset();
		int n;
		wait_start(n);
		repeat (300) @(posedge mclk_i);
		#1;
		reset_and_time();
		one_frame(3'b011);
	endtask : t_mid_reset

	task automatic give_verdict();
		if (n_errors == 0 && samples_checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : give_verdict

	// Main sequence
	initial begin
		mclk_i          = 1'b0;
		srst_i          = 1'b1;
		n_errors        = 0;
		samples_checked = 0;
		cyc             = 0;
		vld             = 3'b111;
		tx              = {16'hFFF0, 16'h8000, 16'h030E};
		ty              = {16'h0001, 16'h7FFF, 16'hF94F};
		ts              = {16'h0010, 16'hFFFF, 16'h0000};
		tg              = {16'h0000, 16'hFFFF, 16'h0140};
		reset_and_time();
		t_frames();
		t_mid_reset();
		give_verdict();
	end
endmodule : tb

bind rtf_framer rtf_framer_monitor #(
	.FRAME_CYCLES_P(FRAME_CYCLES_P),
	.BIT_CYCLES_P  (BIT_CYCLES_P)
) u_mon (
	.mclk_i       (mclk_i),
	.srst_i       (srst_i),
	.txd_o        (txd_o),
	.frame_start_o(frame_start_o),
	.frame_busy_o (frame_busy_o)
);
